/* core/ptc_regs.svh */
// register map, field positions, reset values and divide ratios of the tick counter
// Summary of operation
// RQ1: debug mode freezes prescaler and counter; resume unless cleared meanwhile.
// RQ2: control bit 7 is the match flag, set once count reached wrap limit.
// RQ3: writing 1 clears match flag and its interrupt; writing 0 keeps it.
// RQ4: bits 6-5 pick source: 00 low-power osc, 01 external, 1x internal.
// RQ5: changing source select to a new value clears prescaler and counter.
// RQ6: bit 4 enables interrupt request while match flag set; else poll.
// RQ7: bits 3-0 divider select; a new value clears prescaler and counter.
// RQ8: source low bit 0: off, 8..1024 binary, then 1,2,4,10,16,100,500,1000.
// RQ9: source low bit 1: off, 2^10..2^16, then 1000 up to 200000.
// RQ10: count is read-only; clears on reset, wrap write, select change.
// RQ11: on compare match count returns to zero and match flag sets.
// RQ12: wrap limit zero sets match flag on every prescaler output tick.
// RQ13: any wrap limit write clears prescaler and counter.
// RQ14: reset clears flag, source, enable, divider; wrap limit becomes zero.
// RQ15: count register reads the live counter value.
// RQ16: counter steps once per prescaler period; flag sets on wrap to zero.
// RQ17: a match in the same cycle as a flag clear keeps the flag set.
`ifndef PTC_REGS_SVH
`define PTC_REGS_SVH
// ======================================================================
// byte offsets
`define PTC_OFF_CTRL 5'h00
`define PTC_OFF_COUNT 5'h04
`define PTC_OFF_WRAP 5'h08
`define PTC_OFF_IRQ_STAT 5'h0C
`define PTC_OFF_IRQ_MASK 5'h10
// ======================================================================
// control field positions
`define PTC_FLAG_BIT 7
`define PTC_SRC_HI 6
`define PTC_SRC_LO 5
`define PTC_IE_BIT 4
`define PTC_DIV_HI 3
`define PTC_DIV_LO 0
`define PTC_STAT_BIT 0
// ======================================================================
// reset values
`define PTC_WRAP_RST 8'h00
`define PTC_CNT_RST 8'h00
`define PTC_SRC_RST 2'h0
`define PTC_DIV_RST 4'h0
`define PTC_PRE_RST 18'h00000
`define PTC_MASK_RST 1'b1
// ======================================================================
// divide ratios, zero means prescaler off
`define PTC_DIV_OFF 18'h00000
`define PTC_B0_1 18'h00008
`define PTC_B0_2 18'h00020
`define PTC_B0_3 18'h00040
`define PTC_B0_4 18'h00080
`define PTC_B0_5 18'h00100
`define PTC_B0_6 18'h00200
`define PTC_B0_7 18'h00400
`define PTC_B0_8 18'h00001
`define PTC_B0_9 18'h00002
`define PTC_B0_10 18'h00004
`define PTC_B0_11 18'h0000A
`define PTC_B0_12 18'h00010
`define PTC_B0_13 18'h00064
`define PTC_B0_14 18'h001F4
`define PTC_B0_15 18'h003E8
`define PTC_B1_1 18'h00400
`define PTC_B1_2 18'h00800
`define PTC_B1_3 18'h01000
`define PTC_B1_4 18'h02000
`define PTC_B1_5 18'h04000
`define PTC_B1_6 18'h08000
`define PTC_B1_7 18'h10000
`define PTC_B1_8 18'h003E8
`define PTC_B1_9 18'h007D0
`define PTC_B1_10 18'h01388
`define PTC_B1_11 18'h02710
`define PTC_B1_12 18'h04E20
`define PTC_B1_13 18'h0C350
`define PTC_B1_14 18'h186A0
`define PTC_B1_15 18'h30D40
`endif

/* core/ptc_pkg.sv */
// types shared by the tick counter
package ptc_pkg;
  // ======================================================================
  // prescaler clock sources, taken as levels synchronous to hclk
  typedef struct packed {
    logic int_ref_clock;
    logic ext_ref_clock;
    logic low_power_osc;
  } ptc_src_s;

  // ======================================================================
  // bus phase tracking
  typedef enum logic [1:0] {
    PTC_BUS_IDLE = 2'b00,
    PTC_BUS_WRITE = 2'b01,
    PTC_BUS_READ = 2'b10,
    PTC_BUS_RDONE = 2'b11
  } ptc_bus_e;

  // ======================================================================
  // whole state of the block
  typedef struct packed {
    logic match_flag;
    logic [1:0] source_select;
    logic match_irq_enable;
    logic [3:0] divider_select;
    logic [7:0] wrap_limit;
    logic [7:0] tick_count;
    logic [17:0] pre;
    logic [2:0] src_prev;
    logic irq_mask;
    ptc_bus_e bus;
    logic [4:0] ap_addr;
    logic [31:0] rdata;
  } ptc_state_s;
endpackage

/* core/ptc_top.sv */
// periodic tick counter with AHB-Lite register slave
`include "ptc_regs.svh"

module ptc_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic debug_active,
  input wire ptc_pkg::ptc_src_s src_in,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq
);

  // ======================================================================
  // functions
  function automatic logic [17:0] div_ratio(input logic lo, input logic [3:0] sel);
    logic [17:0] r;
    r = `PTC_DIV_OFF;
    if (!lo) begin // [RQ8]
      case (sel)
        4'h1: r = `PTC_B0_1;
        4'h2: r = `PTC_B0_2;
        4'h3: r = `PTC_B0_3;
        4'h4: r = `PTC_B0_4;
        4'h5: r = `PTC_B0_5;
        4'h6: r = `PTC_B0_6;
        4'h7: r = `PTC_B0_7;
        4'h8: r = `PTC_B0_8;
        4'h9: r = `PTC_B0_9;
        4'hA: r = `PTC_B0_10;
        4'hB: r = `PTC_B0_11;
        4'hC: r = `PTC_B0_12;
        4'hD: r = `PTC_B0_13;
        4'hE: r = `PTC_B0_14;
        4'hF: r = `PTC_B0_15;
        default: r = `PTC_DIV_OFF;
      endcase
    end else begin // [RQ9]
      case (sel)
        4'h1: r = `PTC_B1_1;
        4'h2: r = `PTC_B1_2;
        4'h3: r = `PTC_B1_3;
        4'h4: r = `PTC_B1_4;
        4'h5: r = `PTC_B1_5;
        4'h6: r = `PTC_B1_6;
        4'h7: r = `PTC_B1_7;
        4'h8: r = `PTC_B1_8;
        4'h9: r = `PTC_B1_9;
        4'hA: r = `PTC_B1_10;
        4'hB: r = `PTC_B1_11;
        4'hC: r = `PTC_B1_12;
        4'hD: r = `PTC_B1_13;
        4'hE: r = `PTC_B1_14;
        4'hF: r = `PTC_B1_15;
        default: r = `PTC_DIV_OFF;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] ctrl_byte(input ptc_pkg::ptc_state_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`PTC_FLAG_BIT] = s.match_flag; // [RQ2]
    b[`PTC_SRC_HI:`PTC_SRC_LO] = s.source_select;
    b[`PTC_IE_BIT] = s.match_irq_enable;
    b[`PTC_DIV_HI:`PTC_DIV_LO] = s.divider_select;
    return b;
  endfunction

  // ======================================================================
  // state
  ptc_pkg::ptc_state_s state_ff;
  ptc_pkg::ptc_state_s nxt_state;

  logic [2:0] src_now;
  logic src_level;
  logic src_prev_sel;
  logic src_edge;
  logic [17:0] ratio;
  logic pre_last;
  logic run;
  logic tick;
  logic match_ev;
  logic wr_phase;
  logic wr_ctrl;
  logic wr_wrap;
  logic wr_stat;
  logic wr_mask;
  logic flag_w1c;
  logic sel_chg;
  logic clr_cnt;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  // ======================================================================
  // prescaler input selection and tick generation
  always_comb begin
    src_now = {src_in.int_ref_clock, src_in.ext_ref_clock, src_in.low_power_osc};
    if (state_ff.source_select[1]) begin // [RQ4]
      src_level = src_now[2];
      src_prev_sel = state_ff.src_prev[2];
    end else if (state_ff.source_select[0]) begin
      src_level = src_now[1];
      src_prev_sel = state_ff.src_prev[1];
    end else begin
      src_level = src_now[0];
      src_prev_sel = state_ff.src_prev[0];
    end
    src_edge = src_level & ~src_prev_sel;
    ratio = div_ratio(state_ff.source_select[0], state_ff.divider_select);
    pre_last = (state_ff.pre == (ratio - 18'h00001));
    // counting stops in background debug mode
    run = src_edge & (ratio != `PTC_DIV_OFF) & ~debug_active; // [RQ1]
    tick = run & pre_last; // [RQ16]
    match_ev = tick & (state_ff.tick_count == state_ff.wrap_limit); // [RQ11] [RQ12]
  end

  // ======================================================================
  // register write decode, applied in the data phase
  always_comb begin
    wbyte = hwdata[7:0];
    wr_phase = (state_ff.bus == ptc_pkg::PTC_BUS_WRITE);
    wr_ctrl = wr_phase & (state_ff.ap_addr == `PTC_OFF_CTRL);
    wr_wrap = wr_phase & (state_ff.ap_addr == `PTC_OFF_WRAP);
    wr_stat = wr_phase & (state_ff.ap_addr == `PTC_OFF_IRQ_STAT);
    wr_mask = wr_phase & (state_ff.ap_addr == `PTC_OFF_IRQ_MASK);
    flag_w1c = (wr_ctrl & wbyte[`PTC_FLAG_BIT]) | (wr_stat & wbyte[`PTC_STAT_BIT]); // [RQ3]
    sel_chg = wr_ctrl & ((wbyte[`PTC_SRC_HI:`PTC_SRC_LO] != state_ff.source_select)
        | (wbyte[`PTC_DIV_HI:`PTC_DIV_LO] != state_ff.divider_select)); // [RQ5] [RQ7]
    clr_cnt = sel_chg | wr_wrap; // [RQ10] [RQ13]
  end

  // ======================================================================
  // read mux
  always_comb begin
    rd_mux = 32'h00000000;
    case (state_ff.ap_addr)
      `PTC_OFF_CTRL: rd_mux[7:0] = ctrl_byte(state_ff);
      `PTC_OFF_COUNT: rd_mux[7:0] = state_ff.tick_count; // [RQ15]
      `PTC_OFF_WRAP: rd_mux[7:0] = state_ff.wrap_limit;
      `PTC_OFF_IRQ_STAT: rd_mux[`PTC_STAT_BIT] = state_ff.match_flag;
      `PTC_OFF_IRQ_MASK: rd_mux[`PTC_STAT_BIT] = state_ff.irq_mask;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ======================================================================
  // next state
  always_comb begin
    nxt_state = state_ff;
    nxt_state.src_prev = src_now;

    // prescaler and counter
    if (clr_cnt) begin // [RQ5] [RQ7] [RQ13]
      nxt_state.pre = `PTC_PRE_RST;
      nxt_state.tick_count = `PTC_CNT_RST; // [RQ10]
    end else if (run) begin
      if (pre_last) begin
        nxt_state.pre = `PTC_PRE_RST;
        if (match_ev) begin
          nxt_state.tick_count = `PTC_CNT_RST; // [RQ11]
        end else begin
          nxt_state.tick_count = state_ff.tick_count + 8'h01; // [RQ16]
        end
      end else begin
        nxt_state.pre = state_ff.pre + 18'h00001;
      end
    end

    // flag: a new match wins over a clear in the same cycle
    nxt_state.match_flag = (state_ff.match_flag & ~flag_w1c) | match_ev; // [RQ3] [RQ17]

    // software fields, count register ignores writes
    if (wr_ctrl) begin
      nxt_state.source_select = wbyte[`PTC_SRC_HI:`PTC_SRC_LO]; // [RQ4]
      nxt_state.match_irq_enable = wbyte[`PTC_IE_BIT]; // [RQ6]
      nxt_state.divider_select = wbyte[`PTC_DIV_HI:`PTC_DIV_LO];
    end
    if (wr_wrap) begin
      nxt_state.wrap_limit = wbyte;
    end
    if (wr_mask) begin
      nxt_state.irq_mask = wbyte[`PTC_STAT_BIT];
    end

    // bus phases: writes take no wait, reads take one wait state
    case (state_ff.bus)
      ptc_pkg::PTC_BUS_READ: begin
        nxt_state.rdata = rd_mux;
        nxt_state.bus = ptc_pkg::PTC_BUS_RDONE;
      end
      default: begin
        if (hready && hsel && htrans[1]) begin
          nxt_state.ap_addr = haddr[4:0];
          nxt_state.bus = hwrite ? ptc_pkg::PTC_BUS_WRITE : ptc_pkg::PTC_BUS_READ;
        end else if (hready) begin
          nxt_state.bus = ptc_pkg::PTC_BUS_IDLE;
        end
      end
    endcase
  end

  // ======================================================================
  // state register, frozen while clk_en is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff.match_flag <= 1'b0; // [RQ14]
      state_ff.source_select <= `PTC_SRC_RST;
      state_ff.match_irq_enable <= 1'b0;
      state_ff.divider_select <= `PTC_DIV_RST;
      state_ff.wrap_limit <= `PTC_WRAP_RST;
      state_ff.tick_count <= `PTC_CNT_RST; // [RQ10]
      state_ff.pre <= `PTC_PRE_RST;
      state_ff.src_prev <= 3'h0;
      state_ff.irq_mask <= `PTC_MASK_RST;
      state_ff.bus <= ptc_pkg::PTC_BUS_IDLE;
      state_ff.ap_addr <= 5'h00;
      state_ff.rdata <= 32'h00000000;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  // ======================================================================
  // outputs
  assign hreadyout = clk_en & (state_ff.bus != ptc_pkg::PTC_BUS_READ);
  assign hresp = 1'b0;
  assign hrdata = state_ff.rdata;
  assign irq = state_ff.match_flag & state_ff.match_irq_enable & state_ff.irq_mask; // [RQ6]

  // ======================================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_rd_count_req;
    clk_en && hready && hsel && htrans[1] && !hwrite && haddr[4:0] == `PTC_OFF_COUNT;
  endsequence

  sequence s_rd_wait;
    clk_en && !hreadyout;
  endsequence

  a_wrap_match: assert property ( // [RQ11]
    clk_en && match_ev && !clr_cnt |=> state_ff.tick_count == 8'h00 && state_ff.match_flag)
    else $error("count did not wrap to zero with flag on match");

  a_count_step: assert property ( // [RQ16]
    clk_en && tick && !match_ev && !clr_cnt
      |=> state_ff.tick_count == $past(state_ff.tick_count) + 8'h01)
    else $error("count did not step on prescaler tick");

  a_zero_wrap_flag: assert property ( // [RQ12]
    clk_en && tick && state_ff.wrap_limit == 8'h00 && state_ff.tick_count == 8'h00
      |=> state_ff.match_flag)
    else $error("zero wrap limit did not set flag on tick");

  a_debug_freeze: assert property ( // [RQ1]
    clk_en && debug_active && !clr_cnt |=> $stable(state_ff.tick_count) && $stable(state_ff.pre))
    else $error("counting moved in debug mode");

  a_wrap_write_clr: assert property ( // [RQ13]
    clk_en && wr_wrap |=> state_ff.tick_count == 8'h00 && state_ff.pre == 18'h00000)
    else $error("wrap limit write did not clear counters");

  a_sel_change_clr: assert property ( // [RQ7]
    clk_en && sel_chg |=> state_ff.tick_count == 8'h00 && state_ff.pre == 18'h00000)
    else $error("select change did not clear counters");

  a_flag_clear: assert property ( // [RQ3]
    clk_en && flag_w1c && !match_ev |=> !state_ff.match_flag && !irq)
    else $error("write one did not clear flag");

  a_flag_hold: assert property ( // [RQ2]
    clk_en && state_ff.match_flag && !flag_w1c |=> state_ff.match_flag)
    else $error("flag dropped without clear");

  a_set_wins: assert property ( // [RQ17]
    clk_en && flag_w1c && match_ev |=> state_ff.match_flag)
    else $error("match lost under clear");

  a_irq_raise: assert property ( // [RQ6]
    clk_en && match_ev && state_ff.match_irq_enable && state_ff.irq_mask && !wr_ctrl
      && !wr_mask |=> irq)
    else $error("enabled match did not raise irq");

  a_div_off: assert property ( // [RQ8]
    state_ff.divider_select == 4'h0 |-> !tick)
    else $error("tick with prescaler off");

  a_read_count: assert property ( // [RQ15]
    s_rd_count_req ##1 s_rd_wait ##0 clk_en |=> (hreadyout || !clk_en)
      && hrdata == {24'h000000, $past(state_ff.tick_count)})
    else $error("count read returned wrong value");

  // ======================================================================
  // source, prescaler, counter, flag, interrupt, register and bus invariants
  sequence s_src_rewrite;
    clk_en && wr_ctrl && wbyte[`PTC_SRC_HI:`PTC_SRC_LO] != state_ff.source_select;
  endsequence

  a_src_change_clr: assert property ( // [RQ5]
    s_src_rewrite |=> state_ff.tick_count == `PTC_CNT_RST && state_ff.pre == `PTC_PRE_RST)
    else $error("source change did not clear counters");

  a_low_osc_only: assert property ( // [RQ4]
    clk_en && state_ff.source_select == 2'h0 && !src_in.low_power_osc |-> !tick)
    else $error("tick without low power oscillator edge");

  a_ext_src_only: assert property ( // [RQ4]
    clk_en && state_ff.source_select == 2'h1 && !src_in.ext_ref_clock |-> !tick)
    else $error("tick without external reference edge");

  a_int_src_only: assert property ( // [RQ4]
    clk_en && state_ff.source_select[1] && !src_in.int_ref_clock |-> !tick)
    else $error("tick without internal reference edge");

  a_count_ro: assert property ( // [RQ10]
    clk_en && wr_phase && state_ff.ap_addr == `PTC_OFF_COUNT && !run
      |=> $stable(state_ff.tick_count))
    else $error("count register took a write");

  a_count_idle: assert property ( // [RQ16]
    clk_en && !run && !clr_cnt |=> $stable(state_ff.tick_count))
    else $error("count moved without prescaler activity");

  a_pre_off_hold: assert property ( // [RQ8]
    clk_en && ratio == `PTC_DIV_OFF && !clr_cnt |=> $stable(state_ff.pre))
    else $error("prescaler moved while off");

  a_pre_bound: assert property ( // [RQ8] [RQ9]
    ratio != `PTC_DIV_OFF |-> state_ff.pre < ratio)
    else $error("prescaler beyond its ratio");

  a_debug_no_tick: assert property ( // [RQ1]
    debug_active |-> !tick)
    else $error("tick during debug mode");

  a_flag_only_match: assert property ( // [RQ2]
    clk_en && !state_ff.match_flag && !match_ev |=> !state_ff.match_flag)
    else $error("flag set without match");

  a_irq_off: assert property ( // [RQ6]
    !state_ff.match_irq_enable |-> !irq)
    else $error("irq while interrupt disabled");

  a_irq_follows: assert property ( // [RQ6]
    state_ff.match_flag && state_ff.match_irq_enable && state_ff.irq_mask |-> irq)
    else $error("enabled flag without irq");

  a_wrap_hold: assert property (
    clk_en && !wr_wrap |=> $stable(state_ff.wrap_limit))
    else $error("wrap limit changed without write");

  a_freeze_all: assert property (
    !clk_en |=> $stable(state_ff))
    else $error("state moved with clock enable low");

  a_write_zero_wait: assert property (
    clk_en && state_ff.bus == ptc_pkg::PTC_BUS_WRITE |-> hreadyout)
    else $error("write data phase stalled");

  a_read_one_wait: assert property (
    clk_en && hready && hsel && htrans[1] && !hwrite |=> !hreadyout)
    else $error("read without wait state");

  a_hresp_okay: assert property (
    hresp == 1'b0)
    else $error("response not okay");

endmodule // ptc_top

/* bench/test_periodic_tick_counter.sv */
// self-checking bench for the tick counter over its register bus
`include "ptc_regs.svh"

module test_periodic_tick_counter;
  timeunit 1ns;
  timeprecision 1ps;
  // ======================================================================
  // signals
  logic hclk;
  logic hresetn;
  logic clk_en;
  logic debug_active;
  ptc_pkg::ptc_src_s src_in;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic irq;
  int err_count;
  int total_checks;
  int cycles;
  logic [17:0] ratio0 [1:15];

  assign hready = hreadyout;

  ptc_top i_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .clk_en(clk_en),
    .debug_active(debug_active),
    .src_in(src_in),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .irq(irq)
  );

  // ======================================================================
  // clock and hang guard
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count = err_count + 1;
      print_verdict();
    end
  end

  // ======================================================================
  // tasks
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      err_count = err_count + 1;
    end
  endtask

  // address phase held until hready, then data phase held until hready
  task automatic bus_xfer(input logic [4:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {27'h0000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wr ? d : 32'h00000000;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(a, 1'b1, d, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus_xfer(a, 1'b0, 32'h00000000, q);
    check(q, exp, what);
  endtask

  task automatic irq_chk(input logic exp);
    @(negedge hclk);
    check({31'h00000000, irq}, {31'h00000000, exp}, "irq");
  endtask

  // one rising edge per pulse on the chosen source lines
  task automatic pulse(input logic [2:0] which, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      src_in <= ptc_pkg::ptc_src_s'(which);
      @(posedge hclk);
      src_in <= ptc_pkg::ptc_src_s'(3'b000);
    end
  endtask

  // ======================================================================
  // main sequence
  initial begin
    ratio0 = '{`PTC_B0_1, `PTC_B0_2, `PTC_B0_3, `PTC_B0_4, `PTC_B0_5, `PTC_B0_6, `PTC_B0_7,
               `PTC_B0_8, `PTC_B0_9, `PTC_B0_10, `PTC_B0_11, `PTC_B0_12, `PTC_B0_13,
               `PTC_B0_14, `PTC_B0_15};
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    hresetn = 1'b0;
    clk_en = 1'b1;
    debug_active = 1'b0;
    src_in = ptc_pkg::ptc_src_s'(3'b000);
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`PTC_OFF_CTRL, 32'h00000000, "ctrl reset");
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "count reset");
    rd_chk(`PTC_OFF_WRAP, 32'h00000000, "wrap reset");
    rd_chk(`PTC_OFF_IRQ_MASK, 32'h00000001, "mask reset");
    rd_chk(5'h14, 32'h00000000, "unmapped");
    // wrap at 3 with divide by one
    bus_write(`PTC_OFF_CTRL, 32'h00000008);
    bus_write(`PTC_OFF_WRAP, 32'h00000003);
    pulse(3'b001, 3);
    rd_chk(`PTC_OFF_COUNT, 32'h00000003, "count live");
    rd_chk(`PTC_OFF_CTRL, 32'h00000008, "no flag yet");
    pulse(3'b001, 1);
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "wrapped");
    rd_chk(`PTC_OFF_CTRL, 32'h00000088, "flag set");
    irq_chk(1'b0);
    bus_write(`PTC_OFF_COUNT, 32'h00000055);
    pulse(3'b001, 2);
    rd_chk(`PTC_OFF_COUNT, 32'h00000002, "count ignores write");
    // flag write 0 keeps, enable raises irq, write 1 clears
    bus_write(`PTC_OFF_CTRL, 32'h00000018);
    rd_chk(`PTC_OFF_CTRL, 32'h00000098, "flag kept");
    irq_chk(1'b1);
    bus_write(`PTC_OFF_IRQ_MASK, 32'h00000000);
    irq_chk(1'b0);
    rd_chk(`PTC_OFF_IRQ_STAT, 32'h00000001, "status");
    bus_write(`PTC_OFF_IRQ_MASK, 32'h00000001);
    irq_chk(1'b1);
    bus_write(`PTC_OFF_CTRL, 32'h00000098);
    rd_chk(`PTC_OFF_CTRL, 32'h00000018, "flag cleared");
    irq_chk(1'b0);
    rd_chk(`PTC_OFF_COUNT, 32'h00000002, "same select keeps");
    // debug freeze and resume
    debug_active <= 1'b1;
    pulse(3'b001, 5);
    rd_chk(`PTC_OFF_COUNT, 32'h00000002, "frozen");
    debug_active <= 1'b0;
    pulse(3'b001, 1);
    rd_chk(`PTC_OFF_COUNT, 32'h00000003, "resumed");
    bus_write(`PTC_OFF_WRAP, 32'h00000003);
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "wrap write clears");
    // every binary and decimal ratio with low source bit clear
    bus_write(`PTC_OFF_WRAP, 32'h000000FF);
    for (int k = 1; k < 16; k++) begin
      pulse(3'b001, 1);
      bus_write(`PTC_OFF_CTRL, {28'h0000000, 4'(k)});
      rd_chk(`PTC_OFF_COUNT, 32'h00000000, "divider change clears");
      pulse(3'b001, int'(ratio0[k]) - 1);
      rd_chk(`PTC_OFF_COUNT, 32'h00000000, "before tick");
      pulse(3'b001, 1);
      rd_chk(`PTC_OFF_COUNT, 32'h00000001, "one tick");
    end
    // external source, ratio 1000
    bus_write(`PTC_OFF_CTRL, 32'h00000028);
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "source change clears");
    pulse(3'b011, int'(`PTC_B1_8) - 1);
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "ext before tick");
    pulse(3'b010, 1);
    rd_chk(`PTC_OFF_COUNT, 32'h00000001, "ext tick");
    // internal source with divide by one
    bus_write(`PTC_OFF_CTRL, 32'h00000048);
    pulse(3'b011, 2);
    pulse(3'b100, 2);
    rd_chk(`PTC_OFF_COUNT, 32'h00000002, "int source only");
    // wrap limit zero flags on every prescaler tick
    bus_write(`PTC_OFF_CTRL, 32'h00000008);
    bus_write(`PTC_OFF_WRAP, 32'h00000000);
    pulse(3'b001, 1);
    rd_chk(`PTC_OFF_CTRL, 32'h00000088, "flag at zero limit");
    bus_write(`PTC_OFF_CTRL, 32'h00000088);
    rd_chk(`PTC_OFF_CTRL, 32'h00000008, "cleared");
    pulse(3'b001, 1);
    rd_chk(`PTC_OFF_CTRL, 32'h00000088, "flag again");
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "count stays zero");
    // a match in the data phase of a flag clear keeps the flag
    fork
      bus_write(`PTC_OFF_CTRL, 32'h00000088);
      begin
        repeat (2) @(posedge hclk);
        src_in <= ptc_pkg::ptc_src_s'(3'b001);
        @(posedge hclk);
        src_in <= ptc_pkg::ptc_src_s'(3'b000);
      end
    join
    rd_chk(`PTC_OFF_CTRL, 32'h00000088, "set wins over clear");
    // prescaler off
    bus_write(`PTC_OFF_WRAP, 32'h00000009);
    bus_write(`PTC_OFF_CTRL, 32'h00000080);
    pulse(3'b001, 3);
    rd_chk(`PTC_OFF_COUNT, 32'h00000000, "prescaler off");
    // clock enable low stalls the bus
    @(posedge hclk);
    clk_en <= 1'b0;
    @(negedge hclk);
    check({31'h00000000, hreadyout}, 32'h00000000, "stall");
    check({31'h00000000, hresp}, 32'h00000000, "hresp okay");
    @(posedge hclk);
    clk_en <= 1'b1;
    print_verdict();
  end
endmodule // test_periodic_tick_counter
